// file: logic/sscl_host.sv
`timescale 1ns/1ps
module sscl_host (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link
   sscl_if.host link,
   // load request
   input wire logic start,
   input wire logic [sscl_pkg::ADDR_BITS-1:0] primaryAddr,
   input wire logic [sscl_pkg::ADDR_BITS-1:0] fallbackAddr,
   input wire logic [sscl_pkg::LEN_W-1:0] lenBytes,
   // flash programming
   input wire logic memWrEn,
   input wire logic [sscl_pkg::FLASH_AW-1:0] memAddr,
   input wire logic [7:0] memData,
   // status
   output logic busy,
   output logic loadOk,
   output logic loadFail,
   output logic usedFallback
);
   import sscl_pkg::*;

   typedef enum {H_IDLE, H_CLEAR, H_WAIT, H_XFER, H_CHECK, H_OK, H_FAIL} sscl_hstate_e;
   typedef enum {F_CMD, F_DATA, F_IGNORE} sscl_fstate_e;

   // ***************************************************
   // status synchronisers
   // ***************************************************
   logic [2:0] initSync, doneSync;
   logic initF, doneF;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         initSync <= 3'h0;
         doneSync <= 3'h0;
      end else begin
         initSync <= {initSync[1:0], link.initN};
         doneSync <= {doneSync[1:0], link.done};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         initF <= 1'b0;
         doneF <= 1'b0;
      end else begin
         if (initSync[1] == initSync[2]) initF <= initSync[2];
         if (doneSync[1] == doneSync[2]) doneF <= doneSync[2];
      end
   end

   // ***************************************************
   // serial clock divider
   // ***************************************************
   sscl_hstate_e state_reg;
   logic [DIV_W-1:0] div_reg;
   logic sclk_reg, clocking_reg;
   logic tick, sclkRise, sclkFall;

   assign tick = clocking_reg && (div_reg == DIV_W'(SCLK_HALF_CYC - 1));
   assign sclkRise = tick && !sclk_reg;
   assign sclkFall = tick && sclk_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_reg <= '0;
         sclk_reg <= 1'b0;
      end else if (!clocking_reg) begin
         div_reg <= '0;
         sclk_reg <= 1'b0;
      end else begin
         div_reg <= tick ? '0 : div_reg + DIV_W'(1);
         if (tick) sclk_reg <= ~sclk_reg;
      end
   end

   assign link.sclk = sclk_reg;

   // ***************************************************
   // load sequence
   // ***************************************************
   logic [TIMER_W-1:0] timer_reg;
   logic [XFER_W-1:0] riseCnt_reg;
   logic [XFER_W-1:0] totalBits;
   logic [ADDR_BITS-1:0] addr_reg;
   logic [31:0] cmd_reg;
   logic fallback_reg, progN_reg, csN_reg, lastRise_reg;

   assign totalBits = XFER_W'(CMD_BITS) + XFER_W'({lenBytes, 3'h0});

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= H_IDLE;
         timer_reg <= '0;
         riseCnt_reg <= '0;
         addr_reg <= '0;
         cmd_reg <= 32'h0;
         fallback_reg <= 1'b0;
         progN_reg <= 1'b1;
         csN_reg <= 1'b1;
         clocking_reg <= 1'b0;
         lastRise_reg <= 1'b0;
      end else begin
         case (state_reg)
            H_IDLE, H_OK, H_FAIL: begin
               if (start) begin
                  state_reg <= H_CLEAR;
                  addr_reg <= primaryAddr;
                  fallback_reg <= 1'b0;
                  progN_reg <= 1'b0;
                  timer_reg <= TIMER_W'(PROG_LOW_CYC - 1);
               end
            end
            H_CLEAR: begin
               if (timer_reg == '0) begin
                  progN_reg <= 1'b1;
                  state_reg <= H_WAIT;
                  timer_reg <= TIMER_W'(INIT_RELEASE_CYC + 7);
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            H_WAIT: begin
               // margin over release time covers synchroniser lag
               if (initF || timer_reg == '0) begin
                  state_reg <= H_XFER;
                  cmd_reg <= {READ_CMD, addr_reg};
                  csN_reg <= 1'b0;
                  clocking_reg <= 1'b1;
                  riseCnt_reg <= '0;
                  lastRise_reg <= 1'b0;
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            H_XFER: begin
               if (sclkRise) begin
                  riseCnt_reg <= riseCnt_reg + XFER_W'(1);
                  if (riseCnt_reg == totalBits - XFER_W'(1)) lastRise_reg <= 1'b1;
               end
               if (sclkFall) begin
                  cmd_reg <= {cmd_reg[30:0], 1'b0};
                  if (lastRise_reg) begin
                     clocking_reg <= 1'b0;
                     csN_reg <= 1'b1;
                     state_reg <= H_CHECK;
                     timer_reg <= TIMER_W'(DONE_WAIT_CYC - 1);
                  end
               end
            end
            H_CHECK: begin
               if (timer_reg != '0) begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end else if (initF && doneF) begin
                  state_reg <= H_OK;
               end else if (!fallback_reg) begin
                  fallback_reg <= 1'b1;
                  addr_reg <= fallbackAddr;
                  progN_reg <= 1'b0;
                  state_reg <= H_CLEAR;
                  timer_reg <= TIMER_W'(PROG_LOW_CYC - 1);
               end else begin
                  state_reg <= H_FAIL;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   assign link.progN = progN_reg;
   assign link.csN = csN_reg;
   assign link.mosi = cmd_reg[31];
   assign busy = (state_reg != H_IDLE) && (state_reg != H_OK) && (state_reg != H_FAIL);
   assign loadOk = (state_reg == H_OK);
   assign loadFail = (state_reg == H_FAIL);
   assign usedFallback = fallback_reg;

   // ***************************************************
   // serial flash: array, command decode, data out
   // ***************************************************
   logic [7:0] flashMem [FLASH_BYTES];
   sscl_fstate_e fState_reg;
   logic [4:0] fCnt_reg;
   logic [2:0] fBit_reg;
   logic [31:0] fShift_reg;
   logic [31:0] fShiftNext;
   logic [FLASH_AW-1:0] fAddr_reg;
   logic miso_reg;

   assign fShiftNext = {fShift_reg[30:0], cmd_reg[31]};

   always_ff @(posedge clk) begin
      if (memWrEn) flashMem[memAddr] <= memData;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fState_reg <= F_CMD;
         fCnt_reg <= 5'h0;
         fBit_reg <= 3'h0;
         fShift_reg <= 32'h0;
         fAddr_reg <= '0;
         miso_reg <= 1'b0;
      end else if (csN_reg) begin
         fState_reg <= F_CMD;
         fCnt_reg <= 5'h0;
         fBit_reg <= 3'h0;
         miso_reg <= 1'b0;
      end else begin
         case (fState_reg)
            F_CMD: begin
               if (sclkRise) begin
                  fShift_reg <= fShiftNext;
                  fCnt_reg <= fCnt_reg + 5'h1;
                  if (fCnt_reg == 5'h1f) begin
                     fAddr_reg <= fShiftNext[FLASH_AW-1:0];
                     fState_reg <= (fShiftNext[31:24] == READ_CMD) ? F_DATA : F_IGNORE;
                  end
               end
            end
            F_DATA: begin
               if (sclkFall) begin
                  miso_reg <= flashMem[fAddr_reg][3'h7 - fBit_reg];
                  fBit_reg <= fBit_reg + 3'h1;
                  if (fBit_reg == 3'h7) fAddr_reg <= fAddr_reg + FLASH_AW'(1);
               end
            end
            F_IGNORE: miso_reg <= 1'b0;
            default: fState_reg <= F_CMD;
         endcase
      end
   end

   assign link.miso = miso_reg;

endmodule

// file: logic/sscl_pkg.sv
package sscl_pkg;

   // ***************************************************
   // clock and timing
   // ***************************************************
   localparam int CLK_MHZ = 125;
   localparam int PROG_LOW_NS = 500;
   localparam int INIT_RELEASE_NS = 1000;

   // least time in ns to whole cycles, rounded up, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int PROG_LOW_CYC = ns_to_cyc(PROG_LOW_NS);
   localparam int INIT_RELEASE_CYC = ns_to_cyc(INIT_RELEASE_NS);
   // half period of the serial clock: 10 cycles gives 80 ns
   localparam int SCLK_HALF_CYC = 10;
   localparam int DONE_WAIT_CYC = 64;
   localparam int TIMER_W = 8;
   localparam int DIV_W = 4;

   // ***************************************************
   // command and bitstream layout
   // ***************************************************
   localparam logic [31:0] SYNC_WORD = 32'haa995566;
   localparam int SYNC_WINDOW_BITS = 256;
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam int ADDR_BITS = 24;
   localparam int CMD_BITS = 8 + ADDR_BITS;
   localparam int HUNT_LIMIT = CMD_BITS + SYNC_WINDOW_BITS;
   localparam int HUNT_W = 10;
   localparam int LOAD_WORDS = 16;
   localparam int WORD_CNT_W = 5;
   localparam int FLASH_BYTES = 256;
   localparam int FLASH_AW = 8;
   localparam int LEN_W = 16;
   localparam int XFER_W = 20;

endpackage

// file: logic/sscl_if.sv
`timescale 1ns/1ps
interface sscl_if;
   logic sclk;
   logic csN;
   logic mosi;
   logic miso;
   logic progN;
   logic initN;
   logic done;

   // host: controller plus flash; device: configuration port
   modport host(output sclk, output csN, output mosi, output miso, output progN,
      input initN, input done);
   modport device(input sclk, input miso, input progN, output initN, output done);
endinterface

// file: logic/sscl_device.sv
`timescale 1ns/1ps
module sscl_device (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link
   sscl_if.device link,
   // configuration words
   output logic [31:0] cfgWord,
   output logic cfgValid,
   input wire logic cfgReady,
   // status
   output logic loadError
);
   import sscl_pkg::*;

   typedef enum {D_CLEAR, D_RELEASE, D_HUNT, D_LOAD, D_DONE, D_ERROR} sscl_dstate_e;

   // ***************************************************
   // pin synchronisers, change taken when stages agree
   // ***************************************************
   logic [2:0] sclkSync, misoSync, progSync;
   logic sclkF, misoF, progF, sclkPrev;
   logic sclkRise;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclkSync <= 3'h0;
         misoSync <= 3'h0;
         progSync <= 3'h7;
      end else begin
         sclkSync <= {sclkSync[1:0], link.sclk};
         misoSync <= {misoSync[1:0], link.miso};
         progSync <= {progSync[1:0], link.progN};
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclkF <= 1'b0;
         misoF <= 1'b0;
         progF <= 1'b1;
         sclkPrev <= 1'b0;
      end else begin
         if (sclkSync[1] == sclkSync[2]) sclkF <= sclkSync[2];
         if (misoSync[1] == misoSync[2]) misoF <= misoSync[2];
         if (progSync[1] == progSync[2]) progF <= progSync[2];
         sclkPrev <= sclkF;
      end
   end

   assign sclkRise = sclkF & ~sclkPrev;

   // ***************************************************
   // configuration sequence
   // ***************************************************
   sscl_dstate_e state_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [HUNT_W-1:0] bitCnt_reg;
   logic [WORD_CNT_W-1:0] wordCnt_reg;
   logic [31:0] shift_reg;
   logic [31:0] shiftNext;
   logic pushValid, pushReady;

   assign shiftNext = {shift_reg[30:0], misoF};
   assign pushValid = (state_reg == D_LOAD) && sclkRise && (bitCnt_reg == HUNT_W'(31));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= D_CLEAR;
         timer_reg <= '0;
         bitCnt_reg <= '0;
         wordCnt_reg <= '0;
         shift_reg <= 32'h0;
      end else if (!progF) begin
         state_reg <= D_CLEAR;
      end else begin
         case (state_reg)
            D_CLEAR: begin
               state_reg <= D_RELEASE;
               timer_reg <= TIMER_W'(INIT_RELEASE_CYC - 1);
            end
            D_RELEASE: begin
               if (timer_reg == '0) begin
                  state_reg <= D_HUNT;
                  bitCnt_reg <= '0;
                  shift_reg <= 32'h0;
               end else begin
                  timer_reg <= timer_reg - TIMER_W'(1);
               end
            end
            D_HUNT: begin
               if (sclkRise) begin
                  shift_reg <= shiftNext;
                  bitCnt_reg <= bitCnt_reg + HUNT_W'(1);
                  if (shiftNext == SYNC_WORD) begin
                     state_reg <= D_LOAD;
                     bitCnt_reg <= '0;
                     wordCnt_reg <= '0;
                  end else if (bitCnt_reg == HUNT_W'(HUNT_LIMIT - 1)) begin
                     state_reg <= D_ERROR;
                  end
               end
            end
            D_LOAD: begin
               if (sclkRise) begin
                  shift_reg <= shiftNext;
                  bitCnt_reg <= (bitCnt_reg == HUNT_W'(31)) ? '0 : bitCnt_reg + HUNT_W'(1);
                  if (pushValid) begin
                     wordCnt_reg <= wordCnt_reg + WORD_CNT_W'(1);
                     if (!pushReady) state_reg <= D_ERROR;
                     else if (wordCnt_reg == WORD_CNT_W'(LOAD_WORDS - 1)) state_reg <= D_DONE;
                  end
               end
            end
            D_DONE: state_reg <= D_DONE;
            D_ERROR: state_reg <= D_ERROR;
            default: state_reg <= D_CLEAR;
         endcase
      end
   end

   // ***************************************************
   // status pins
   // ***************************************************
   logic initN_reg, done_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         initN_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         initN_reg <= (state_reg == D_HUNT) || (state_reg == D_LOAD) || (state_reg == D_DONE);
         done_reg <= (state_reg == D_DONE);
      end
   end

   assign link.initN = initN_reg;
   assign link.done = done_reg;
   assign loadError = (state_reg == D_ERROR);

   // ***************************************************
   // two-entry word buffer
   // ***************************************************
   logic [31:0] buf_reg [2];
   logic wrPtr_reg, rdPtr_reg;
   logic [1:0] count_reg;
   logic push, pop;

   assign pushReady = (count_reg != 2'h2);
   assign push = pushValid && pushReady;
   assign pop = cfgValid && cfgReady;
   assign cfgValid = (count_reg != 2'h0);
   assign cfgWord = buf_reg[rdPtr_reg];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         buf_reg[0] <= 32'h0;
         buf_reg[1] <= 32'h0;
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else if (!progF) begin
         wrPtr_reg <= 1'b0;
         rdPtr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            buf_reg[wrPtr_reg] <= shiftNext;
            wrPtr_reg <= ~wrPtr_reg;
         end
         if (pop) rdPtr_reg <= ~rdPtr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// file: tb/sscl_monitor.sv
`timescale 1ns/1ps
module sscl_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // link
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   input wire logic miso,
   input wire logic progN,
   input wire logic initN,
   input wire logic done
);
   import sscl_pkg::*;
   logic [7:0] lowCnt;
   logic [7:0] holdCnt;
   logic sclkQ;

   default clocking monClk @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ******
   // helper counters
   // ******
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lowCnt <= 8'h00;
      end else if (!progN) begin
         lowCnt <= (lowCnt == 8'hff) ? lowCnt : lowCnt + 8'h01;
      end else begin
         lowCnt <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclkQ <= 1'b0;
         holdCnt <= 8'h00;
      end else begin
         sclkQ <= sclk;
         if (sclk != sclkQ) begin
            holdCnt <= 8'h00;
         end else if (holdCnt != 8'hff) begin
            holdCnt <= holdCnt + 8'h01;
         end
      end
   end

   // ******
   // link rules
   // ******
   a_clear_low_len: assert property ($rose(progN) |-> lowCnt == 8'(PROG_LOW_CYC))
      else $error("clear pulse length wrong");
   a_prog_high_frame: assert property (!csN |-> progN)
      else $error("clear low during read");
   a_init_on_clear: assert property ($fell(progN) |-> ##[1:6] !initN)
      else $error("init not low after clear");
   a_done_on_clear: assert property ($fell(progN) |-> ##[1:6] !done)
      else $error("done not dropped by clear");
   a_done_holds: assert property ((done && progN) ##1 progN |-> done)
      else $error("done fell without clear");
   a_read_after_init: assert property ($fell(csN) |-> initN)
      else $error("read began before init release");
   a_sclk_in_frame: assert property ($changed(sclk) |-> !$past(csN))
      else $error("serial clock edge outside frame");
   a_frame_end_low: assert property ($rose(csN) |-> !sclk)
      else $error("frame ended with clock high");
   a_half_period: assert property ($changed(sclk) |-> holdCnt >= 8'(SCLK_HALF_CYC - 1))
      else $error("serial clock half period short");
   a_cmd_lead: assert property ($fell(csN) |-> !mosi)
      else $error("command first bit wrong");
endmodule

// file: tb/sscl_tb.sv
`timescale 1ns/1ps
module sscl_tb;
   import sscl_pkg::*;
   localparam int LIMIT = 80000;
   logic clk;
   logic resetn;
   logic start;
   logic [ADDR_BITS-1:0] primaryAddr;
   logic [ADDR_BITS-1:0] fallbackAddr;
   logic [LEN_W-1:0] lenBytes;
   logic memWrEn;
   logic [FLASH_AW-1:0] memAddr;
   logic [7:0] memData;
   logic busy, loadOk, loadFail, usedFallback;
   logic [31:0] cfgWord;
   logic cfgValid, cfgReady, loadError;
   logic [1:0] readyMode;
   logic [7:0] flashImg [256];
   logic [31:0] got [$];
   logic [31:0] cmdSeen;
   logic [7:0] byteSeen;
   int rises;
   int pad2;
   int failures;
   int comparisons;
   int cyc;

   sscl_if lnk ();
   sscl_host sscl_host_i (.clk(clk), .resetn(resetn), .link(lnk.host), .start(start),
      .primaryAddr(primaryAddr), .fallbackAddr(fallbackAddr), .lenBytes(lenBytes),
      .memWrEn(memWrEn), .memAddr(memAddr), .memData(memData), .busy(busy),
      .loadOk(loadOk), .loadFail(loadFail), .usedFallback(usedFallback));
   sscl_device sscl_device_i (.clk(clk), .resetn(resetn), .link(lnk.device),
      .cfgWord(cfgWord), .cfgValid(cfgValid), .cfgReady(cfgReady), .loadError(loadError));
   sscl_monitor sscl_monitor_i (.clk(clk), .resetn(resetn), .sclk(lnk.sclk), .csN(lnk.csN),
      .mosi(lnk.mosi), .miso(lnk.miso), .progN(lnk.progN), .initN(lnk.initN), .done(lnk.done));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ******
   // wire watch, sink and timeout
   // ******
   always @(negedge lnk.csN) begin
      rises = 0;
   end
   always @(posedge lnk.sclk) begin
      if (lnk.csN === 1'b0) begin
         if (rises < CMD_BITS) cmdSeen = {cmdSeen[30:0], lnk.mosi};
         else if (rises < CMD_BITS + 8) byteSeen = {byteSeen[6:0], lnk.miso};
         rises = rises + 1;
      end
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cfgValid === 1'b1 && cfgReady === 1'b1) got.push_back(cfgWord);
      #1;
      cfgReady = readyMode[1] | (readyMode[0] & 1'($urandom));
      if (cyc == LIMIT) begin
         failures = failures + 1;
         final_report();
      end
   end

   // ******
   // tasks
   // ******
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic put_img(input int base, input int pad, input int words);
      logic [7:0] b;
      for (int i = 0; i < pad + 4 + 4 * words; i++) begin
         if (i >= pad && i < pad + 4) b = SYNC_WORD[31 - 8 * (i - pad) -: 8];
         else b = 8'($urandom);
         flashImg[base + i] = b;
         memWrEn = 1'b1;
         memAddr = 8'(base + i);
         memData = b;
         step();
      end
      memWrEn = 1'b0;
   endtask
   function automatic logic [31:0] exp_word(input int base, input int pad, input int k);
      int b;
      b = base + pad + 4 + 4 * k;
      return {flashImg[b], flashImg[b + 1], flashImg[b + 2], flashImg[b + 3]};
   endfunction
   task automatic run_load(input int len);
      got.delete();
      lenBytes = 16'(len);
      start = 1'b1;
      step();
      start = 1'b0;
      while (busy !== 1'b0) step();
   endtask
   task automatic check_words(input int base, input int pad, input int n);
      check(32'(got.size()), 32'(n));
      for (int k = 0; k < n && k < got.size(); k++) check(got[k], exp_word(base, pad, k));
   endtask
   task automatic check_wire(input logic [23:0] addr, input int len);
      check(cmdSeen, {READ_CMD, addr});
      check(32'(rises), 32'(CMD_BITS + 8 * len));
      check({24'h0, byteSeen}, {24'h0, flashImg[addr[7:0]]});
   endtask

   // ******
   // main sequence
   // ******
   initial begin
      resetn = 1'b0;
      start = 1'b0;
      primaryAddr = '0;
      fallbackAddr = '0;
      lenBytes = '0;
      memWrEn = 1'b0;
      memAddr = '0;
      memData = '0;
      cfgReady = 1'b0;
      readyMode = 2'b01;
      failures = 0;
      comparisons = 0;
      cyc = 0;
      rises = 0;
      void'($urandom(32'h9dc196cd));
      repeat (6) @(posedge clk);
      #1;
      resetn = 1'b1;
      // sync ends on the last bit of the window
      put_img(0, 28, LOAD_WORDS);
      primaryAddr = {16'($urandom), 8'h00};
      fallbackAddr = {16'($urandom), 8'h80};
      run_load(96);
      check(32'(loadOk), 32'h1);
      check(32'(usedFallback), 32'h0);
      check(32'(lnk.done), 32'h1);
      check_words(0, 28, LOAD_WORDS);
      check_wire(primaryAddr, 96);
      $display("test 1 done");
      // sync one byte past the window, good fallback
      put_img(0, 29, LOAD_WORDS);
      pad2 = $urandom_range(4);
      put_img(128, pad2, LOAD_WORDS);
      run_load(97);
      check(32'(loadOk), 32'h1);
      check(32'(usedFallback), 32'h1);
      check_words(128, pad2, LOAD_WORDS);
      check_wire(fallbackAddr, 97);
      $display("test 2 done");
      // receiver stalls, buffer overflows on both tries
      readyMode = 2'b00;
      put_img(128, 0, 4);
      primaryAddr = fallbackAddr;
      run_load(20);
      check(32'(loadFail), 32'h1);
      check(32'(loadError), 32'h1);
      check(32'(lnk.done), 32'h0);
      readyMode = 2'b10;
      repeat (6) step();
      check_words(128, 0, 2);
      check(32'(cfgValid), 32'h0);
      $display("test 3 done");
      final_report();
   end
endmodule
